// >>> mei_pkg.sv
// Shared constants, register map and types for the memory error block.
// Assumes a single 25 MHz controller clock and a plain register port.
package mei_pkg;

  // ==========================================================================
  // Widths and register map
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 4;
  localparam int NUM_ERR = 8;
  localparam int SEL_W   = 2;
  localparam int NUM_INT = 4;
  localparam int CTL_W   = NUM_ERR * SEL_W;
  localparam int FSM_W   = 4;

  localparam logic [ADDR_W-1:0] A_LOG   = 4'h0;
  localparam logic [ADDR_W-1:0] A_CTL   = 4'h1;
  localparam logic [ADDR_W-1:0] A_IEN   = 4'h2;
  localparam logic [ADDR_W-1:0] A_CFG   = 4'h3;
  localparam logic [ADDR_W-1:0] A_SPARE = 4'h4;
  localparam logic [ADDR_W-1:0] A_STAT  = 4'h5;

  // ==========================================================================
  // Error log bit positions
  localparam int E_PARITY = 0;
  localparam int E_FSM    = 1;
  localparam int E_NB_UNC = 2;
  localparam int E_SB_UNC = 3;
  localparam int E_THERM  = 4;
  localparam int E_ALERT  = 5;
  localparam int E_CORR   = 6;
  localparam int E_PERF   = 7;

  // Defaults suit mirroring off and poison off.
  localparam logic [CTL_W-1:0]   RST_CTL    = 16'h49FF;
  localparam logic [NUM_ERR-1:0] RST_IEN    = 8'hFF;
  localparam logic [NUM_ERR-1:0] FATAL_MASK = 8'h0F;
  localparam logic [NUM_ERR-1:0] THERM_ONLY = 8'h10;

  // ==========================================================================
  // Status register fields
  localparam int ST_FATAL    = 0;
  localparam int ST_CONFLICT = 1;
  localparam int ST_FLOW_LSB = 8;

  // ==========================================================================
  // Channel pairs and the idle code of watched state machines
  localparam logic [3:0]       PAIR_AB  = 4'h3;
  localparam logic [3:0]       PAIR_CD  = 4'hC;
  localparam logic [3:0]       CH_NONE  = 4'h0;
  localparam logic [FSM_W-1:0] FSM_IDLE = 4'h1;

  localparam logic [1:0] SPM_OFF  = 2'h0;
  localparam logic [1:0] SPM_COPY = 2'h1;
  localparam logic [1:0] SPM_ON   = 2'h2;

  typedef struct packed {
    logic       poison_en;
    logic       mirror_en;
    logic       migrate_en;
    logic       hemi_en;
    logic       rank_spare;
    logic [1:0] spare_mode;
    logic       rsvd;
  } mei_cfg_t;

  typedef struct packed {
    logic [1:0] mod;
    logic [1:0] rank;
  } mei_loc_t;

  typedef struct packed {
    mei_loc_t fail;
    mei_loc_t spare;
  } mei_spare_t;

  localparam logic [7:0] RST_CFG   = 8'h00;
  localparam logic [7:0] RST_SPARE = 8'h00;

  typedef enum logic [4:0] {
    FL_IDLE = 5'h01,
    FL_NB_TR = 5'h02,
    FL_NB_PE = 5'h04,
    FL_SB_TR = 5'h08,
    FL_SB_PE = 5'h10
  } mei_flow_t;

endpackage

// >>> mei_err_flow.sv
// Error flow machine that retries link CRC errors and alert frames.
// Assumes all inputs come from logic on clk.
`timescale 1ns/1ps
module mei_err_flow (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       nb_crc_err,
  input  wire logic       sb_alert,
  input  wire logic       replay_done,
  input  wire logic       replay_ok,
  input  wire logic       link_reset_done,
  output logic            replay_req,
  output logic            soft_rst,
  output logic            fast_rst,
  output logic            nb_uncorr,
  output logic            sb_uncorr,
  output mei_pkg::mei_flow_t flow_state
);

  mei_pkg::mei_flow_t st_r;
  mei_pkg::mei_flow_t st_nxt;
  logic               replay_nxt;
  logic               soft_nxt;
  logic               fast_nxt;
  logic               nbu_nxt;
  logic               sbu_nxt;

  // ==========================================================================
  // Transitions
  always_comb begin
    st_nxt     = st_r;
    replay_nxt = 1'b0;
    soft_nxt   = 1'b0;
    fast_nxt   = 1'b0;
    nbu_nxt    = 1'b0;
    sbu_nxt    = 1'b0;
    case (st_r)
      mei_pkg::FL_IDLE: begin
        if (nb_crc_err) begin
          st_nxt     = mei_pkg::FL_NB_TR;
          replay_nxt = 1'b1;
        end else if (sb_alert) begin
          st_nxt   = mei_pkg::FL_SB_TR;
          soft_nxt = 1'b1;
        end
      end
      mei_pkg::FL_NB_TR: begin
        if (replay_done && replay_ok) begin
          st_nxt = mei_pkg::FL_IDLE;
        end else if (replay_done) begin
          st_nxt     = mei_pkg::FL_NB_PE;
          replay_nxt = 1'b1;
        end
      end
      mei_pkg::FL_NB_PE: begin
        if (replay_done) begin
          st_nxt  = mei_pkg::FL_IDLE;
          nbu_nxt = !replay_ok;
        end
      end
      mei_pkg::FL_SB_TR: begin
        if (sb_alert) begin
          st_nxt   = mei_pkg::FL_SB_PE;
          fast_nxt = 1'b1;
        end else if (link_reset_done) begin
          st_nxt = mei_pkg::FL_IDLE;
        end
      end
      mei_pkg::FL_SB_PE: begin
        if (sb_alert) begin
          st_nxt  = mei_pkg::FL_IDLE;
          sbu_nxt = 1'b1;
        end else if (link_reset_done) begin
          st_nxt = mei_pkg::FL_IDLE;
        end
      end
      default: begin
        st_nxt = mei_pkg::FL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r       <= mei_pkg::FL_IDLE;
      replay_req <= 1'b0;
      soft_rst   <= 1'b0;
      fast_rst   <= 1'b0;
      nb_uncorr  <= 1'b0;
      sb_uncorr  <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      replay_req <= replay_nxt;
      soft_rst   <= soft_nxt;
      fast_rst   <= fast_nxt;
      nb_uncorr  <= nbu_nxt;
      sb_uncorr  <= sbu_nxt;
    end
  end

  assign flow_state = st_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Being in the persistent state already means the first replay failed.
  sequence s_nb_two_fails;
    st_r == mei_pkg::FL_NB_PE && replay_done && !replay_ok;
  endsequence

  a_nb_retry_first: assert property (
    st_r == mei_pkg::FL_IDLE && nb_crc_err
    |=> replay_req && st_r == mei_pkg::FL_NB_TR)
    else $error("link crc error did not start a replay");
  a_nb_two_fails: assert property (
    s_nb_two_fails |=> nb_uncorr && st_r == mei_pkg::FL_IDLE)
    else $error("two failed replays did not report uncorrectable");
  a_sb_soft_first: assert property (
    st_r == mei_pkg::FL_IDLE && !nb_crc_err && sb_alert
    |=> soft_rst && !sb_uncorr)
    else $error("alert frame did not start a soft link reset");

endmodule

// >>> mei_core.sv
// Error logging, interrupt steering, fatal handling and access routing.
// Assumes error and request inputs come from logic on clk.
//
// Function
// - Each logged error has a two-bit control field choosing its interrupt.
// - Each of four interrupt outputs pulses one cycle per new error.
// - Thermal and alert errors interrupt only when their log bit sets.
// - A fatal event pulses fatal, then every transaction is force-acked.
// - Non-critical errors keep running; firmware services logs without deadline.
// - Queue data parity is checked; a mismatch is unhandleable.
// - Illegal state machine transitions log an unhandleable error.
// - Frame type, write and read dispatch machines are watched.
// - Link CRC errors and alert frames are retried before interrupting.
// - Lock-step accesses always use pair A and B or C and D.
// - A designated spare stays out of the address space until active.
// - Module sparing copies a whole module; rank sparing copies one rank.
// - Sparing stays inside this controller; no spare of another one.
// - In hemisphere mode the first agent never reaches the second home.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module mei_core (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic [mei_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [mei_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [mei_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                       q_rvalid,
  input  wire logic [mei_pkg::DATA_W-1:0] q_rdata,
  input  wire logic                       q_rpar,
  input  wire logic [mei_pkg::FSM_W-1:0]  frame_state,
  input  wire logic [mei_pkg::FSM_W-1:0]  wdq_state,
  input  wire logic [mei_pkg::FSM_W-1:0]  rdq_state,
  input  wire logic                       nb_crc_err,
  input  wire logic                       sb_alert,
  input  wire logic                       replay_done,
  input  wire logic                       replay_ok,
  input  wire logic                       link_reset_done,
  input  wire logic                       thermal_evt,
  input  wire logic                       status_alert_evt,
  input  wire logic                       corr_err,
  input  wire logic                       perf_evt,
  input  wire logic                       txn_req,
  input  wire logic                       txn_down_ack,
  output logic                            txn_ack,
  input  wire logic                       acc_valid,
  input  wire mei_pkg::mei_loc_t          acc_loc,
  input  wire logic                       acc_pair_cd,
  input  wire logic                       acc_agent_first,
  input  wire logic                       acc_home_second,
  output logic      [3:0]                 ch_req,
  output mei_pkg::mei_loc_t               ch_loc,
  output logic                            acc_block,
  output logic                            copy_en,
  output logic                            copy_whole_mod,
  output mei_pkg::mei_loc_t               copy_src,
  output mei_pkg::mei_loc_t               copy_dst,
  output logic                            replay_req,
  output logic                            soft_rst,
  output logic                            fast_rst,
  output logic [mei_pkg::NUM_INT-1:0]     int_out,
  output logic                            fatal_pulse
);

  // ==========================================================================
  // Helper functions
  function automatic logic fsm_bad(input logic [mei_pkg::FSM_W-1:0] prev,
                                   input logic [mei_pkg::FSM_W-1:0] cur);
    logic onehot;
    logic legal;
    onehot = (cur != '0) && ((cur & (cur - 1'b1)) == '0);
    legal  = (cur == prev) || (cur == {prev[mei_pkg::FSM_W-2:0],
              prev[mei_pkg::FSM_W-1]}) || (cur == mei_pkg::FSM_IDLE);
    return !(onehot && legal);
  endfunction

  function automatic logic par_bad(input logic [mei_pkg::DATA_W-1:0] d,
                                   input logic p);
    return (^d) != p;
  endfunction

  // ==========================================================================
  // Registers and wires
  logic [mei_pkg::NUM_ERR-1:0] log_r;
  logic [mei_pkg::NUM_ERR-1:0] log_nxt;
  logic [mei_pkg::CTL_W-1:0]   ctl_r;
  logic [mei_pkg::NUM_ERR-1:0] ien_r;
  mei_pkg::mei_cfg_t           cfg_r;
  mei_pkg::mei_spare_t         spare_r;
  logic                        fatal_r;
  logic [mei_pkg::FSM_W-1:0]   frame_prev_r;
  logic [mei_pkg::FSM_W-1:0]   wdq_prev_r;
  logic [mei_pkg::FSM_W-1:0]   rdq_prev_r;
  logic [mei_pkg::NUM_INT-1:0] int_nxt;
  logic [mei_pkg::DATA_W-1:0]  rd_mux;
  logic [mei_pkg::NUM_ERR-1:0] det;
  logic [mei_pkg::NUM_ERR-1:0] new_err;
  logic [mei_pkg::NUM_ERR-1:0] clr_vec;
  logic                        nb_uncorr;
  logic                        sb_uncorr;
  logic                        fatal_now;
  logic                        conflict;
  logic [1:0]                  spare_mode;
  logic                        fail_hit;
  logic                        spare_hit;
  logic                        reserved_hit;
  logic                        hemi_blk;
  logic                        blk;
  mei_pkg::mei_loc_t           route_loc;
  mei_pkg::mei_flow_t          flow_state;

  mei_err_flow u_flow (
    .clk             (clk),
    .nrst            (nrst),
    .nb_crc_err      (nb_crc_err),
    .sb_alert        (sb_alert),
    .replay_done     (replay_done),
    .replay_ok       (replay_ok),
    .link_reset_done (link_reset_done),
    .replay_req      (replay_req),
    .soft_rst        (soft_rst),
    .fast_rst        (fast_rst),
    .nb_uncorr       (nb_uncorr),
    .sb_uncorr       (sb_uncorr),
    .flow_state      (flow_state)
  );

  // ==========================================================================
  // Error detection
  assign det[mei_pkg::E_PARITY] = q_rvalid && par_bad(q_rdata, q_rpar);
  assign det[mei_pkg::E_FSM]    = fsm_bad(frame_prev_r, frame_state) ||
                                  fsm_bad(wdq_prev_r, wdq_state) ||
                                  fsm_bad(rdq_prev_r, rdq_state);
  assign det[mei_pkg::E_NB_UNC] = nb_uncorr;
  assign det[mei_pkg::E_SB_UNC] = sb_uncorr;
  assign det[mei_pkg::E_THERM]  = thermal_evt;
  assign det[mei_pkg::E_ALERT]  = status_alert_evt;
  assign det[mei_pkg::E_CORR]   = corr_err;
  assign det[mei_pkg::E_PERF]   = perf_evt;

  // Only a clear-to-set change counts, so a held log bit raises nothing.
  assign new_err   = det & ~log_r;
  assign clr_vec   = (reg_wr && reg_addr == mei_pkg::A_LOG) ?
                     reg_wdata[mei_pkg::NUM_ERR-1:0] : '0;
  assign log_nxt   = (log_r & ~clr_vec) | det;
  assign fatal_now = |(det & mei_pkg::FATAL_MASK);

  // Each error's two-bit field picks the output; its enable bit can mute it.
  always_comb begin
    int_nxt = '0;
    for (int i = 0; i < mei_pkg::NUM_ERR; i++) begin
      if (new_err[i] && ien_r[i]) begin
        int_nxt[ctl_r[i*mei_pkg::SEL_W +: mei_pkg::SEL_W]] = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Sparing, lock-step and hemisphere routing
  assign conflict   = (cfg_r.spare_mode != mei_pkg::SPM_OFF) &&
                      (cfg_r.mirror_en || cfg_r.migrate_en);
  assign spare_mode = conflict ? mei_pkg::SPM_OFF : cfg_r.spare_mode;
  assign fail_hit   = cfg_r.rank_spare ? (acc_loc == spare_r.fail) :
                      (acc_loc.mod == spare_r.fail.mod);
  assign spare_hit  = cfg_r.rank_spare ? (acc_loc == spare_r.spare) :
                      (acc_loc.mod == spare_r.spare.mod);
  // The spare fields name a module and rank of this controller only.
  assign route_loc  = (spare_mode == mei_pkg::SPM_ON && fail_hit) ?
                      (cfg_r.rank_spare ? spare_r.spare :
                      {spare_r.spare.mod, acc_loc.rank}) : acc_loc;
  assign reserved_hit = (spare_mode != mei_pkg::SPM_OFF) && spare_hit &&
                        !(spare_mode == mei_pkg::SPM_ON && fail_hit);
  assign hemi_blk   = cfg_r.hemi_en && acc_agent_first &&
                      acc_home_second;
  assign blk        = fatal_r || hemi_blk || reserved_hit;

  // ==========================================================================
  // Register read decode
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      mei_pkg::A_LOG:   rd_mux[mei_pkg::NUM_ERR-1:0] = log_r;
      mei_pkg::A_CTL:   rd_mux[mei_pkg::CTL_W-1:0]   = ctl_r;
      mei_pkg::A_IEN:   rd_mux[mei_pkg::NUM_ERR-1:0] = ien_r;
      mei_pkg::A_CFG:   rd_mux[7:0] = cfg_r;
      mei_pkg::A_SPARE: rd_mux[7:0] = spare_r;
      mei_pkg::A_STAT: begin
        rd_mux[mei_pkg::ST_FATAL]    = fatal_r;
        rd_mux[mei_pkg::ST_CONFLICT] = conflict;
        rd_mux[mei_pkg::ST_FLOW_LSB +: 5] = flow_state;
      end
      default: rd_mux = '0;
    endcase
  end

  // ==========================================================================
  // Register state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctl_r     <= mei_pkg::RST_CTL;
      ien_r     <= mei_pkg::RST_IEN;
      cfg_r     <= mei_pkg::RST_CFG;
      spare_r   <= mei_pkg::RST_SPARE;
      reg_rdata <= '0;
    end else begin
      if (reg_wr && reg_addr == mei_pkg::A_CTL) begin
        ctl_r <= reg_wdata[mei_pkg::CTL_W-1:0];
      end
      if (reg_wr && reg_addr == mei_pkg::A_IEN) begin
        ien_r <= reg_wdata[mei_pkg::NUM_ERR-1:0];
      end
      if (reg_wr && reg_addr == mei_pkg::A_CFG) begin
        cfg_r <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == mei_pkg::A_SPARE) begin
        spare_r <= reg_wdata[7:0];
      end
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

  // ==========================================================================
  // Error state, interrupts and fatal handling
  always_ff @(posedge clk) begin
    if (!nrst) begin
      log_r        <= '0;
      fatal_r      <= 1'b0;
      fatal_pulse  <= 1'b0;
      int_out      <= '0;
      frame_prev_r <= mei_pkg::FSM_IDLE;
      wdq_prev_r   <= mei_pkg::FSM_IDLE;
      rdq_prev_r   <= mei_pkg::FSM_IDLE;
    end else begin
      log_r        <= log_nxt;
      fatal_r      <= fatal_r || fatal_now;
      fatal_pulse  <= fatal_now && !fatal_r;
      int_out      <= int_nxt;
      frame_prev_r <= frame_state;
      wdq_prev_r   <= wdq_state;
      rdq_prev_r   <= rdq_state;
    end
  end

  // After a fatal event every request is acknowledged without service.
  assign txn_ack = fatal_r ? txn_req : (txn_req && txn_down_ack);

  // ==========================================================================
  // Access and copy outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ch_req         <= mei_pkg::CH_NONE;
      ch_loc         <= '0;
      acc_block      <= 1'b0;
      copy_en        <= 1'b0;
      copy_whole_mod <= 1'b0;
      copy_src       <= '0;
      copy_dst       <= '0;
    end else begin
      ch_req    <= (acc_valid && !blk) ? (acc_pair_cd ? mei_pkg::PAIR_CD :
                   mei_pkg::PAIR_AB) : mei_pkg::CH_NONE;
      ch_loc    <= route_loc;
      acc_block <= acc_valid && blk;
      copy_en   <= spare_mode == mei_pkg::SPM_COPY;
      copy_whole_mod <= !cfg_r.rank_spare;
      copy_src  <= spare_r.fail;
      copy_dst  <= spare_r.spare;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_bad_frame;
    fsm_bad(frame_prev_r, frame_state);
  endsequence

  // Two new errors on consecutive cycles may legally keep a line high.
  a_int_single: assert property ((int_out & $past(int_out)) == '0 ||
    $past(new_err) != '0)
    else $error("interrupt output held for more than one cycle");
  a_int_cause: assert property (
    int_out != '0 |-> (log_r & ~$past(log_r)) != '0)
    else $error("interrupt without a newly set log bit");
  a_therm_held: assert property (
    det == mei_pkg::THERM_ONLY && log_r[mei_pkg::E_THERM]
    |=> int_out == '0)
    else $error("held thermal bit raised an interrupt");
  a_log_sticky: assert property (
    (($past(log_r) & ~log_r) & ~$past(clr_vec)) == '0)
    else $error("log bit dropped without a clear");
  a_fatal_edge: assert property (
    fatal_pulse |-> fatal_r && !$past(fatal_r))
    else $error("fatal pulse not at the fatal onset");
  a_forced_ack: assert property (fatal_r && txn_req |-> txn_ack)
    else $error("request not force-acknowledged after fatal");
  a_fatal_hold: assert property (fatal_r |=> fatal_r && ch_req == '0)
    else $error("fatal state left without reset");
  a_parity_fatal: assert property (
    q_rvalid && par_bad(q_rdata, q_rpar)
    |=> log_r[mei_pkg::E_PARITY] && fatal_r)
    else $error("queue parity error not logged as fatal");
  a_fsm_logged: assert property (
    s_bad_frame |=> log_r[mei_pkg::E_FSM] && fatal_r)
    else $error("illegal frame type transition not logged");
  a_pair_whole: assert property (
    ch_req == mei_pkg::CH_NONE || ch_req == mei_pkg::PAIR_AB ||
    ch_req == mei_pkg::PAIR_CD)
    else $error("access not spread over a channel pair");
  a_spare_hidden: assert property (
    acc_valid && reserved_hit |=> acc_block && ch_req == '0)
    else $error("reserved spare reached by an access");
  a_hemi_block: assert property (
    acc_valid && hemi_blk |=> acc_block && ch_req == '0)
    else $error("hemisphere access to second home not blocked");

endmodule

// >>> mei_agent_model.sv
// Coherence agent side model: answers transactions sent downstream.
// Assumes the core's clock and its synchronous active-low reset.
`timescale 1ns/1ps
module mei_agent_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic stall,
  input  wire logic txn_req,
  output logic      txn_down_ack
);
  // One ack per request a cycle later; a stall withholds it.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      txn_down_ack <= 1'b0;
    end else begin
      txn_down_ack <= txn_req & ~stall & ~txn_down_ack;
    end
  end
endmodule

// >>> test_memory_error_interrupt_logic.sv
// Self-checking bench for the memory error interrupt core.
// Assumes a 25 MHz clock and the agent model on the transaction side.
`timescale 1ns/1ps
module test_memory_error_interrupt_logic;
  logic clk, nrst, reg_wr, reg_rd, q_rvalid, q_rpar, nb_crc_err, sb_alert;
  logic replay_done, replay_ok, link_reset_done, thermal_evt, perf_evt;
  logic status_alert_evt, corr_err, txn_req, txn_down_ack, txn_ack;
  logic acc_valid, acc_pair_cd, acc_agent_first, acc_home_second, stall;
  logic replay_req, fatal_pulse, acc_block, soft_rst, fast_rst;
  logic [9:0] cp;
  logic [3:0] reg_addr, frame_state, wdq_state, rdq_state, ch_req, int_out;
  logic [31:0] reg_wdata, reg_rdata, q_rdata;
  mei_pkg::mei_loc_t acc_loc, ch_loc;
  int n_errors, checks_done, cyc, fatals;
  int pulses[4];
  mei_core mei_core_inst (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .q_rvalid, .q_rdata, .q_rpar, .frame_state,
    .wdq_state, .rdq_state, .nb_crc_err, .sb_alert, .replay_done,
    .replay_ok, .link_reset_done, .thermal_evt, .status_alert_evt,
    .corr_err, .perf_evt, .txn_req, .txn_down_ack, .txn_ack, .acc_valid,
    .acc_loc, .acc_pair_cd, .acc_agent_first, .acc_home_second, .ch_req,
    .ch_loc, .acc_block, .copy_en(cp[9]), .copy_whole_mod(cp[8]),
    .copy_src(cp[7:4]), .copy_dst(cp[3:0]), .replay_req, .soft_rst,
    .fast_rst, .int_out, .fatal_pulse);
  mei_agent_model mei_agent_model_inst (.clk, .nrst, .stall, .txn_req,
    .txn_down_ack);
  // ===========================================================
  // Clock, timeout and pulse counting
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) pulses[i] += int_out[i] === 1'b1;
    fatals += fatal_pulse === 1'b1;
  end
  // ===========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input string w, input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(w, e, reg_rdata);
  endtask
  task automatic acc(input logic cd, af, hs, input logic [4:0] e);
    @(posedge clk);
    {acc_valid, acc_pair_cd, acc_agent_first, acc_home_second} <= {1'b1, cd, af, hs};
    @(posedge clk);
    acc_valid <= 1'b0;
    #1;
    chk("block,ch_req", {27'h0, e}, {27'h0, acc_block, ch_req});
  endtask
  task automatic drive(input int k, input logic v);
    case (k)
      0: thermal_evt <= v;
      1: corr_err <= v;
      2: replay_done <= v;
      3: q_rvalid <= v;
      4: rdq_state[0] <= v;
      5: nb_crc_err <= v;
      6: sb_alert <= v;
      default: link_reset_done <= v;
    endcase
  endtask
  task automatic pulse_in(input int k, input int n);
    @(posedge clk);
    drive(k, 1'b1);
    repeat (n) @(posedge clk);
    drive(k, 1'b0);
    repeat (3) @(posedge clk);
  endtask
  task automatic kick(input int k);
    @(posedge clk);
    drive(k, 1'b1);
    @(posedge clk);
    drive(k, 1'b0);
    #1;
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ===========================================================
  // Scenarios
  task automatic t_regs_irq();
    int p;
    rd("ctl", mei_pkg::A_CTL, {16'h0, mei_pkg::RST_CTL});
    rd("unmapped", 4'h9, 32'h0);
    p = pulses[1];
    pulse_in(0, 6);
    chk("therm pulses", p + 1, pulses[1]);
    rd("log", mei_pkg::A_LOG, 32'h10);
    wr(mei_pkg::A_LOG, 32'h10);
    pulse_in(0, 1);
    chk("therm again", p + 2, pulses[1]);
    wr(mei_pkg::A_CTL, 32'h69FF);
    p = pulses[2];
    pulse_in(1, 1);
    chk("corr steer", p + 1, pulses[2]);
    wr(mei_pkg::A_IEN, 32'hBF);
    wr(mei_pkg::A_LOG, 32'h40);
    pulse_in(1, 1);
    chk("corr masked", p + 1, pulses[2]);
    rd("log masked", mei_pkg::A_LOG, 32'h50);
    $display("test regs_irq done");
  endtask
  task automatic t_access_flow();
    acc(1'b0, 1'b1, 1'b1, 5'h03);
    acc(1'b1, 1'b0, 1'b0, 5'h0C);
    wr(mei_pkg::A_CFG, 32'h10);
    acc(1'b0, 1'b1, 1'b1, 5'h10);
    kick(5);
    chk("replay_req", 32'h1, {31'h0, replay_req});
    pulse_in(2, 1);
    kick(6);
    chk("soft_rst", 32'h1, {31'h0, soft_rst});
    kick(6);
    chk("fast_rst", 32'h1, {31'h0, fast_rst});
    pulse_in(7, 1);
    rd("stat idle", mei_pkg::A_STAT, 32'h100);
    $display("test access_flow done");
  endtask
  task automatic t_spare();
    wr(mei_pkg::A_SPARE, 32'h4D);
    wr(mei_pkg::A_CFG, 32'h02);
    acc_loc <= 4'hD;
    acc(1'b0, 1'b0, 1'b0, 5'h10);
    chk("copy", 32'h34D, {22'h0, cp});
    wr(mei_pkg::A_CFG, 32'h04);
    acc_loc <= 4'h6;
    acc(1'b0, 1'b0, 1'b0, 5'h03);
    chk("ch_loc", 32'hE, {28'h0, ch_loc});
    wr(mei_pkg::A_CFG, 32'h44);
    rd("conflict", mei_pkg::A_STAT, 32'h102);
    $display("test spare done");
  endtask
  task automatic t_fatal();
    @(posedge clk);
    stall <= 1'b1;
    txn_req <= 1'b1;
    {q_rdata, q_rpar} <= {32'h1, 1'b0};
    pulse_in(3, 1);
    chk("fatal count", 32'h1, fatals);
    chk("int3", 32'h1, pulses[3]);
    chk("forced ack", 32'h1, {31'h0, txn_ack});
    acc(1'b0, 1'b0, 1'b0, 5'h10);
    @(posedge clk);
    do_reset();
    @(posedge clk);
    #1;
    chk("ack after reset", 32'h0, {31'h0, txn_ack});
    @(posedge clk);
    frame_state <= 4'h4;
    pulse_in(4, 1);
    chk("fsm int3", 32'h2, pulses[3]);
    rd("fsm log", mei_pkg::A_LOG, 32'h02);
    $display("test fatal done");
  endtask
  initial begin
    clk = 1'b0;
    {nrst, reg_wr, reg_rd, q_rvalid, q_rpar, nb_crc_err, sb_alert} = '0;
    {replay_done, link_reset_done, thermal_evt, perf_evt} = '0;
    replay_ok = 1'b1;
    {status_alert_evt, corr_err, txn_req, acc_valid, acc_pair_cd} = '0;
    {acc_agent_first, acc_home_second, stall, reg_addr} = '0;
    {reg_wdata, q_rdata, acc_loc} = '0;
    {frame_state, wdq_state} = {2{mei_pkg::FSM_IDLE}};
    rdq_state = mei_pkg::FSM_IDLE;
    {n_errors, checks_done, cyc, fatals} = '0;
    pulses = '{0, 0, 0, 0};
    do_reset();
    t_regs_irq();
    t_access_flow();
    t_spare();
    t_fatal();
    test_done();
  end
endmodule
